// [design/fault_action_engine.sv]
/*
  Fault response engine for one channel: response setting, restart wait,
  latched status bits and alert masking, reached through a command port.
  Assumes the command port is fed by the serial interface logic on clk_in,
  one command per valid cycle; analog detector levels arrive unsynchronised.
*/
`default_nettype none
`include "fault_resp_consts.svh"
module fault_action_engine
  import fault_resp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic run_in,
  input wire logic ton_fault_det_in,
  input wire logic fault_pin_low_in,
  input wire logic vout_decayed_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic channel_en_out,
  output logic alert_n_out
);
  // Synchroniser lanes
  localparam int SY_RUN = 0;
  localparam int SY_TON = 1;
  localparam int SY_PIN = 2;
  localparam int SY_DECAY = 3;

  // Mask slot for each status code; valid is low for refused codes
  function automatic logic [3:0] mask_slot(input logic [7:0] code);
    logic [3:0] r;
    r = 4'h0;
    case (code)
      `CODE_STATUS_VOUT: r = 4'h8;
      `CODE_STATUS_IOUT: r = 4'h9;
      `CODE_STATUS_TEMP: r = 4'hA;
      `CODE_STATUS_CML: r = 4'hB;
      `CODE_STATUS_INPUT: r = 4'hC;
      `CODE_STATUS_MFR: r = 4'hD;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Write-one-to-clear of a latched status register
  function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] ones);
    return old & ~ones;
  endfunction

  // Summary bits of the status word, built from the latched registers
  function automatic logic [15:0] status_word(input logic [7:0] vout, input logic [7:0] mfr,
      input logic [7:0] comm_memory_logic_fault);
    logic [15:0] w;
    w = 16'h0000;
    w[`WORD_VOUT_BIT] = |vout;
    w[`WORD_MFR_BIT] = |mfr;
    w[`WORD_CML_BIT] = |comm_memory_logic_fault;
    return w;
  endfunction

  engine_s q, d;
  retry_if rif ();
  logic [15:0] interval_ms;
  logic run_lvl, ton_lvl, pin_lvl, decay_lvl;
  logic clear_evt, off_on_evt;
  logic [3:0] slot;
  logic [2:0] slot_idx;
  logic [7:0] set_vout, set_cml, set_mfr;
  logic [7:0] mask_vout, mask_cml, mask_mfr;
  logic unmasked_new;

  linear11_to_ms u_conv (
    .word_in(q.restart_interval),
    .ms_out(interval_ms)
  );

  retry_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tif(rif.timer)
  );

  assign run_lvl = q.sync[SY_RUN];
  assign ton_lvl = q.sync[SY_TON];
  assign pin_lvl = q.sync[SY_PIN];
  assign decay_lvl = q.sync[SY_DECAY];
  assign slot = mask_slot(cmd_data_in[7:0]);
  assign slot_idx = slot[2:0];
  assign mask_vout = q.masks[0];
  assign mask_cml = q.masks[3];
  assign mask_mfr = q.masks[5];
  assign rif.interval_ms = interval_ms;

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    rif.start = 1'b0;
    rif.clear = 1'b0;
    set_vout = 8'h00;
    set_cml = 8'h00;
    set_mfr = 8'h00;
    clear_evt = 1'b0;

    d.meta = {vout_decayed_in, fault_pin_low_in, ton_fault_det_in, run_in};
    d.sync = q.meta;
    // Edge detectors reset low, the idle level of every detector
    d.fault_prev = ton_lvl;
    d.pin_prev = pin_lvl;
    d.run_prev = run_lvl;
    off_on_evt = run_lvl && !q.run_prev;

    // Detector events latch status whatever the action field holds
    if (ton_lvl && !q.fault_prev) begin
      set_vout[`VOUT_TON_BIT] = 1'b1;
    end
    if (pin_lvl && !q.pin_prev) begin
      set_mfr[`MFR_PIN_LOW_BIT] = 1'b1;
    end

    // Command port
    if (cmd_valid_in) begin
      case (cmd_code_in)
        `CODE_FAULT_ACTION: begin
          if (!cmd_write_in) begin
            d.rsp_valid = 1'b1;
            d.rsp_data = {8'h00, q.fault_action};
          end else if (cmd_data_in[`ACT_HI:`ACT_LO] == `ACT_CONTINUE ||
                       cmd_data_in[`ACT_HI:`ACT_LO] == `ACT_SHUTDOWN) begin
            // Delay bits dropped so they never steer anything
            d.fault_action = cmd_data_in[7:0] & `DELAY_FIELD_MASK;
          end else begin
            set_cml[`CML_DATA_BIT] = 1'b1;
          end
        end
        `CODE_RESTART_INTERVAL: begin
          if (cmd_write_in) begin
            // Range is the host's duty; any word is stored
            d.restart_interval = cmd_data_in;
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = q.restart_interval;
          end
        end
        `CODE_CHAN_CONFIG: begin
          if (cmd_write_in) begin
            d.chan_config = cmd_data_in[7:0];
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = {8'h00, q.chan_config};
          end
        end
        `CODE_ALERT_MASK: begin
          if (!slot[3]) begin
            set_cml[`CML_DATA_BIT] = 1'b1;
          end else if (cmd_write_in) begin
            d.masks[slot_idx] = cmd_data_in[15:8];
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = {8'h00, q.masks[slot_idx]};
          end
        end
        `CODE_STATUS_VOUT: begin
          if (cmd_write_in) begin
            d.status_vout = w1c(q.status_vout, cmd_data_in[7:0]);
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = {8'h00, q.status_vout};
          end
        end
        `CODE_STATUS_CML: begin
          if (cmd_write_in) begin
            d.status_cml = w1c(q.status_cml, cmd_data_in[7:0]);
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = {8'h00, q.status_cml};
          end
        end
        `CODE_STATUS_MFR: begin
          if (cmd_write_in) begin
            d.status_mfr = w1c(q.status_mfr, cmd_data_in[7:0]);
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = {8'h00, q.status_mfr};
          end
        end
        `CODE_STATUS_WORD: begin
          if (cmd_write_in) begin
            set_cml[`CML_CMD_BIT] = 1'b1;
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_data = status_word(q.status_vout, q.status_mfr, q.status_cml);
          end
        end
        `CODE_CLEAR_FAULTS: begin
          clear_evt = cmd_write_in;
        end
        `CODE_RESTORE: begin
          clear_evt = cmd_write_in;
        end
        `CODE_DEVICE_RESET: begin
          clear_evt = cmd_write_in;
          if (cmd_write_in) begin
            d.masks = '0;
            d.masks[5] = `RST_MASK_MFR;
            d.fault_action = `RST_FAULT_ACTION;
            d.restart_interval = `RST_RESTART_INTERVAL;
            d.chan_config = `RST_CHAN_CONFIG;
          end
        end
        default: begin
          set_cml[`CML_CMD_BIT] = 1'b1;
        end
      endcase
    end

    // Off then on also clears the latched bits
    if (clear_evt || off_on_evt) begin
      d.status_vout = 8'h00;
      d.status_cml = 8'h00;
      d.status_mfr = 8'h00;
    end
    // Sets applied last so an event in a clearing cycle survives
    d.status_vout = d.status_vout | set_vout;
    d.status_cml = d.status_cml | set_cml;
    d.status_mfr = d.status_mfr | set_mfr;

    // Masked bits latch but never raise the line
    unmasked_new = |(set_vout & ~q.status_vout & ~mask_vout) ||
                   |(set_cml & ~q.status_cml & ~mask_cml) ||
                   |(set_mfr & ~q.status_mfr & ~mask_mfr);
    // Line stays while any latched bit remains
    d.alert_n = !(unmasked_new ||
                  (!q.alert_n && |{d.status_vout, d.status_cml, d.status_mfr}));

    // Channel state
    case (q.state)
      ST_OFF: begin
        d.chan_en = 1'b0;
        if (run_lvl) begin
          d.state = ST_RUN;
          d.chan_en = 1'b1;
        end
      end
      ST_RUN: begin
        d.chan_en = 1'b1;
        if (ton_lvl && q.fault_action[`ACT_HI:`ACT_LO] == `ACT_SHUTDOWN) begin
          d.chan_en = 1'b0;
          if (q.fault_action[`RETRY_HI:`RETRY_LO] == `RETRY_ENDLESS) begin
            d.state = ST_WAIT_RELEASE;
          end else begin
            d.state = ST_HELD;
          end
        end
        // Action 00 leaves the channel untouched
      end
      ST_HELD: begin
        // Clearing the fault grants one restart after the wait
        d.chan_en = 1'b0;
        if (clear_evt) begin
          d.state = ST_WAIT_RELEASE;
        end
      end
      ST_WAIT_RELEASE: begin
        // Both the detector and the shared pin must let go first
        d.chan_en = 1'b0;
        if (!ton_lvl && !pin_lvl) begin
          rif.start = 1'b1;
          d.state = ST_WAIT_RETRY;
        end
      end
      ST_WAIT_RETRY: begin
        d.chan_en = 1'b0;
        if (rif.done &&
            (q.chan_config[`CFG_DECAY_OFF_BIT] || decay_lvl)) begin
          d.state = ST_RUN;
          d.chan_en = 1'b1;
        end
      end
      default: begin
        d.state = ST_OFF;
        d.chan_en = 1'b0;
      end
    endcase

    // Commanded off wins over every state and drops the wait
    if (!run_lvl) begin
      d.state = ST_OFF;
      d.chan_en = 1'b0;
      rif.start = 1'b0;
      // Wait restarts from zero after any off period
      rif.clear = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.state <= ST_OFF;
      q.fault_action <= `RST_FAULT_ACTION;
      q.restart_interval <= `RST_RESTART_INTERVAL;
      q.chan_config <= `RST_CHAN_CONFIG;
      q.masks <= '0;
      q.masks[5] <= `RST_MASK_MFR;
      q.alert_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rsp_valid_out = q.rsp_valid;
  assign rsp_data_out = q.rsp_data;
  assign channel_en_out = q.chan_en;
  assign alert_n_out = q.alert_n;
endmodule // fault_action_engine
`default_nettype wire

// [design/fault_resp_consts.svh]
/*
  Constants of the fault response engine: command codes, field positions,
  reset values and timing counts.
  Assumes a 10 MHz system clock; included by the engine, the assertions, the bench and the host model.
*/
`ifndef FAULT_RESP_CONSTS_SVH
`define FAULT_RESP_CONSTS_SVH

// Command codes seen on the command port
`define CODE_CLEAR_FAULTS 8'h03
`define CODE_RESTORE 8'h16
`define CODE_ALERT_MASK 8'h1B
`define CODE_FAULT_ACTION 8'h63
`define CODE_STATUS_WORD 8'h79
`define CODE_STATUS_VOUT 8'h7A
`define CODE_STATUS_IOUT 8'h7B
`define CODE_STATUS_INPUT 8'h7C
`define CODE_STATUS_TEMP 8'h7D
`define CODE_STATUS_CML 8'h7E
`define CODE_STATUS_MFR 8'h80
`define CODE_CHAN_CONFIG 8'hD0
`define CODE_RESTART_INTERVAL 8'hDB
`define CODE_DEVICE_RESET 8'hFD

// Fault action setting fields
`define ACT_HI 7
`define ACT_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define ACT_CONTINUE 2'h0
`define ACT_SHUTDOWN 2'h2
`define RETRY_ENDLESS 3'h7
`define DELAY_FIELD_MASK 8'hF8

// Status and config bit positions
`define VOUT_TON_BIT 2
`define CML_DATA_BIT 6
`define CML_CMD_BIT 7
`define MFR_PIN_LOW_BIT 0
`define WORD_VOUT_BIT 15
`define WORD_MFR_BIT 12
`define WORD_CML_BIT 1
`define CFG_DECAY_OFF_BIT 0

// Reset values
`define RST_FAULT_ACTION 8'h80
`define RST_RESTART_INTERVAL 16'h00FA
`define RST_MASK 8'h00
`define RST_MASK_MFR 8'h11
`define RST_CHAN_CONFIG 8'h00

// Timing
`define CLK_PERIOD_NS 100
`define TIME_MS_NS 1000000
`define MS_CYCLES (`TIME_MS_NS / `CLK_PERIOD_NS)

`endif

// [design/fault_resp_pkg.sv]
/*
  Types shared by the fault response engine and its restart timer.
  Assumes the constants header is on the include path.
*/
`default_nettype none
package fault_resp_pkg;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_RUN = 5'b00010,
    ST_HELD = 5'b00100,
    ST_WAIT_RELEASE = 5'b01000,
    ST_WAIT_RETRY = 5'b10000
  } chan_state_e;

  typedef struct packed {
    logic [15:0] presc;
    logic [15:0] ms;
    logic active;
    logic done;
  } timer_s;

  typedef struct packed {
    chan_state_e state;
    logic [3:0] meta;
    logic [3:0] sync;
    logic fault_prev;
    logic pin_prev;
    logic run_prev;
    logic [7:0] fault_action;
    logic [15:0] restart_interval;
    logic [7:0] chan_config;
    logic [5:0][7:0] masks;
    logic [7:0] status_vout;
    logic [7:0] status_cml;
    logic [7:0] status_mfr;
    logic alert_n;
    logic chan_en;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } engine_s;

endpackage
`default_nettype wire

// [design/linear11_to_ms.sv]
/*
  Converts a linear word (5-bit exponent, 11-bit mantissa) to whole ms.
  Assumes nonnegative intervals; a negative mantissa reads as zero.
*/
`default_nettype none
module linear11_to_ms (
  input wire logic [15:0] word_in,
  output logic [15:0] ms_out
);
  logic [31:0] wide;
  logic [4:0] nexp;

  always_comb begin
    wide = 32'h0000_0000;
    nexp = 5'h00;
    ms_out = 16'h0000;
    if (!word_in[10]) begin
      if (!word_in[15]) begin
        wide = {21'h00_0000, word_in[10:0]} << word_in[14:11];
        // Saturate rather than wrap on huge exponents
        ms_out = (|wide[31:16]) ? 16'hFFFF : wide[15:0];
      end else begin
        nexp = 5'(~word_in[15:11] + 5'h01);
        ms_out = {5'h00, word_in[10:0] >> nexp};
      end
    end
  end
endmodule // linear11_to_ms

// [design/retry_if.sv]
/*
  Carrier between the engine and its restart timer.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface retry_if;
  logic start;
  logic clear;
  logic [15:0] interval_ms;
  logic done;
  modport engine (output start, output clear, output interval_ms, input done);
  modport timer (input start, input clear, input interval_ms, output done);
endinterface
`default_nettype wire

// [design/retry_timer.sv]
/*
  Millisecond restart wait timer with its own tick prescaler.
  Assumes start is a single-cycle request from the engine; clear is held for as long as run is low.
*/
`default_nettype none
module retry_timer
  import fault_resp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  retry_if.timer tif
);
  localparam logic [15:0] PRESC_LAST = 16'(MS_CYCLES - 1);
  timer_s q, d;

  always_comb begin
    d = q;
    if (tif.clear) begin
      d = '0;
    end else if (tif.start) begin
      d = '0;
      d.active = 1'b1;
    end else if (q.active) begin
      if (q.presc == PRESC_LAST) begin
        d.presc = 16'h0000;
        d.ms = q.ms + 16'h0001;
        if (q.ms + 16'h0001 >= tif.interval_ms) begin
          d.active = 1'b0;
          d.done = 1'b1;
        end
      end else begin
        d.presc = q.presc + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.done = q.done;
endmodule // retry_timer

// [test/fault_action_engine_asserts.sv]
/*
  Port-level assertions for the fault response engine, bound to its top.
  Assumes one clock domain and an active-high asynchronous reset.
*/
`default_nettype none
`include "fault_resp_consts.svh"
module fault_action_engine_asserts
  import fault_resp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic run_in,
  input wire logic ton_fault_det_in,
  input wire logic fault_pin_low_in,
  input wire logic vout_decayed_in,
  input wire logic rsp_valid_out,
  input wire logic [15:0] rsp_data_out,
  input wire logic channel_en_out,
  input wire logic alert_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] act_q;
  logic vmask_q;
  logic nodecay_q;
  logic wr;
  assign wr = cmd_valid_in && cmd_write_in;
  // Shadow of the settings that decide what the outputs may do
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in || (wr && cmd_code_in == `CODE_DEVICE_RESET)) begin
      act_q <= `RST_FAULT_ACTION;
      vmask_q <= 1'b0;
      nodecay_q <= 1'b0;
    end else if (wr) begin
      if (cmd_code_in == `CODE_FAULT_ACTION && !cmd_data_in[6]) begin
        act_q <= cmd_data_in[7:0];
      end
      if (cmd_code_in == `CODE_ALERT_MASK && cmd_data_in[7:0] == `CODE_STATUS_VOUT) begin
        vmask_q <= cmd_data_in[8+`VOUT_TON_BIT];
      end
      if (cmd_code_in == `CODE_CHAN_CONFIG) begin
        nodecay_q <= cmd_data_in[0];
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reset_quiet_a: assert property ($fell(rst_in) |-> alert_n_out && !channel_en_out)
    else $error("outputs not idle after reset");
  mask_answer_a: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == `CODE_ALERT_MASK
    && cmd_data_in[7:0] inside {8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80} |=> rsp_valid_out)
    else $error("mask read not answered");
  shut_at_once_a: assert property ((act_q[7:6] == `ACT_SHUTDOWN && ton_fault_det_in)[*3]
    |-> ##[1:3] !channel_en_out)
    else $error("output not shut on fault");
  keep_running_a: assert property ((act_q[7:6] == `ACT_CONTINUE && run_in && channel_en_out)[*3]
    |=> channel_en_out)
    else $error("output dropped with continue action");
  alert_fault_a: assert property (!ton_fault_det_in ##1 (ton_fault_det_in && !vmask_q
    && !cmd_valid_in)[*3] |-> ##[1:3] !alert_n_out)
    else $error("fault did not raise alert");
  alert_masked_a: assert property (alert_n_out && !ton_fault_det_in ##1 (ton_fault_det_in
    && vmask_q && !cmd_valid_in)[*3] |=> alert_n_out[*3])
    else $error("masked fault raised alert");
  decay_hold_a: assert property ((run_in && !vout_decayed_in && !nodecay_q
    && act_q[5:3] == `RETRY_ENDLESS && !channel_en_out)[*6] |=> !channel_en_out)
    else $error("restart before output decayed");
  clear_release_a: assert property ((!$rose(ton_fault_det_in) && !$rose(fault_pin_low_in))[*4]
    ##1 (wr && cmd_code_in == `CODE_CLEAR_FAULTS) |-> ##[1:2] alert_n_out)
    else $error("alert kept after clear");
  cover property (rsp_valid_out);
  cover property ($fell(channel_en_out));
  cover property ($rose(channel_en_out) && act_q[5:3] == `RETRY_ENDLESS);
endmodule // fault_action_engine_asserts

bind fault_action_engine fault_action_engine_asserts #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk_in,
  .rst_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_data_in, .run_in, .ton_fault_det_in,
  .fault_pin_low_in, .vout_decayed_in, .rsp_valid_out, .rsp_data_out, .channel_en_out,
  .alert_n_out);
`default_nettype wire

// [test/fault_action_engine_tb.sv]
/*
  Self-checking bench for the fault response engine.
  Assumes the host model drives the command port; 10 ms-cycles per ms.
*/
`default_nettype none
`include "fault_resp_consts.svh"
module fault_action_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_in, valid, write, run, ton, pin, decay, rsp_valid, en, alert_n, g;
  logic [7:0] code;
  logic [15:0] data, rsp_data, r;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] codes [6] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
  logic [7:0] bad [2] = '{8'h40, 8'hFF};
  fault_action_engine #(.MS_CYCLES(10)) i_fault_action_engine (.clk_in(clk_in),
    .rst_in(rst_in), .cmd_valid_in(valid), .cmd_write_in(write), .cmd_code_in(code),
    .cmd_data_in(data), .run_in(run), .ton_fault_det_in(ton), .fault_pin_low_in(pin),
    .vout_decayed_in(decay), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .channel_en_out(en), .alert_n_out(alert_n));
  pmbus_host_model i_pmbus_host_model (.clk_in(clk_in), .rsp_valid_in(rsp_valid),
    .rsp_data_in(rsp_data), .valid_out(valid), .write_out(write), .code_out(code),
    .data_out(data));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out;
    end
  end
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_pmbus_host_model.xfer(1'b1, c, d, g, r);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [15:0] exp);
    i_pmbus_host_model.xfer(1'b0, c, {8'h00, a}, g, r);
    check({g, r}, {1'b1, exp});
  endtask
  // Bounded wait for the enable, then its delay is held against a window
  task automatic wait_en(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (en !== v && n < hi) begin
      step(1);
      n++;
    end
    check({16'h0000, n >= lo && en === v}, 17'h00001);
  endtask
  task automatic fault_cycle(input int lo, input int hi);
    ton = 1'b1;
    wait_en(1'b0, 1, 5);
    ton = 1'b0;
    wait_en(1'b1, lo, hi);
  endtask
  initial begin
    rst_in = 1'b1;
    {run, ton, pin} = 3'b000;
    decay = 1'b1;
    step(10);
    rst_in = 1'b0;
    foreach (codes[k]) begin
      rd(`CODE_ALERT_MASK, codes[k], k == 5 ? 16'h0011 : 16'h0000);
    end
    i_pmbus_host_model.xfer(1'b0, `CODE_ALERT_MASK, 16'h0079, g, r);
    check({16'h0000, g}, 17'h00000);
    rd(`CODE_STATUS_CML, 8'h00, 16'h0040);
    check({16'h0000, alert_n}, 17'h00000);
    wr(`CODE_STATUS_CML, 16'h0040);
    step(2);
    check({16'h0000, alert_n}, 17'h00001);
    pin = 1'b1;
    step(4);
    rd(`CODE_STATUS_MFR, 8'h00, 16'h0001);
    check({16'h0000, alert_n}, 17'h00001);
    rd(`CODE_STATUS_WORD, 8'h00, 16'h1000);
    pin = 1'b0;
    wr(8'h40, 16'h0000);
    rd(`CODE_STATUS_CML, 8'h00, 16'h0080);
    check({16'h0000, alert_n}, 17'h00000);
    wr(`CODE_RESTORE, 16'h0000);
    rd(`CODE_STATUS_MFR, 8'h00, 16'h0000);
    check({16'h0000, alert_n}, 17'h00001);
    $display("test masks done");
    wr(`CODE_FAULT_ACTION, 16'h00BF);
    rd(`CODE_FAULT_ACTION, 8'h00, 16'h00B8);
    foreach (bad[k]) begin
      wr(`CODE_FAULT_ACTION, {8'h00, bad[k]});
      rd(`CODE_STATUS_CML, 8'h00, 16'h0040);
      wr(`CODE_STATUS_CML, 16'h0040);
      rd(`CODE_FAULT_ACTION, 8'h00, 16'h00B8);
    end
    $display("test setting done");
    i_pmbus_host_model.set_interval(120);
    run = 1'b1;
    wait_en(1'b1, 0, 10);
    ton = 1'b1;
    wait_en(1'b0, 1, 5);
    rd(`CODE_STATUS_WORD, 8'h00, 16'h8000);
    rd(`CODE_STATUS_VOUT, 8'h00, 16'h0004);
    check({16'h0000, alert_n}, 17'h00000);
    step(1500);
    check({16'h0000, en}, 17'h00000);
    ton = 1'b0;
    wait_en(1'b1, 1200, 1215);
    decay = 1'b0;
    ton = 1'b1;
    wait_en(1'b0, 1, 5);
    ton = 1'b0;
    step(1400);
    check({16'h0000, en}, 17'h00000);
    decay = 1'b1;
    wait_en(1'b1, 1, 6);
    wr(`CODE_CHAN_CONFIG, 16'h0001);
    decay = 1'b0;
    fault_cycle(1200, 1215);
    decay = 1'b1;
    wr(`CODE_CLEAR_FAULTS, 16'h0000);
    rd(`CODE_STATUS_VOUT, 8'h00, 16'h0000);
    $display("test retry done");
    wr(`CODE_ALERT_MASK, 16'h047A);
    rd(`CODE_ALERT_MASK, 8'h7A, 16'h0004);
    wr(`CODE_FAULT_ACTION, 16'h0080);
    ton = 1'b1;
    wait_en(1'b0, 1, 5);
    rd(`CODE_STATUS_VOUT, 8'h00, 16'h0004);
    check({16'h0000, alert_n}, 17'h00001);
    ton = 1'b0;
    step(1400);
    check({16'h0000, en}, 17'h00000);
    run = 1'b0;
    step(5);
    run = 1'b1;
    wait_en(1'b1, 0, 10);
    rd(`CODE_STATUS_VOUT, 8'h00, 16'h0000);
    $display("test mask and hold done");
    wr(`CODE_ALERT_MASK, 16'h007A);
    wr(`CODE_FAULT_ACTION, 16'h0000);
    ton = 1'b1;
    step(10);
    check({16'h0000, en}, 17'h00001);
    check({16'h0000, alert_n}, 17'h00000);
    wr(`CODE_DEVICE_RESET, 16'h0000);
    step(2);
    rd(`CODE_ALERT_MASK, 8'h80, 16'h0011);
    rd(`CODE_STATUS_VOUT, 8'h00, 16'h0000);
    $display("test continue done");
    close_out;
  end
endmodule // fault_action_engine_tb
`default_nettype wire

// [test/pmbus_host_model.sv]
/*
  Host model: issues commands on the engine's command port.
  Assumes reads are answered on the taking edge, sampled just after it.
*/
`default_nettype none
`include "fault_resp_consts.svh"
module pmbus_host_model (
  input wire logic clk_in,
  input wire logic rsp_valid_in,
  input wire logic [15:0] rsp_data_in,
  output logic valid_out,
  output logic write_out,
  output logic [7:0] code_out,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_out = 1'b0;
    write_out = 1'b0;
    code_out = 8'h00;
    data_out = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic got, output logic [15:0] rd);
    @(posedge clk_in);
    #1;
    valid_out = 1'b1;
    write_out = w;
    code_out = c;
    data_out = d;
    @(posedge clk_in);
    #1;
    got = rsp_valid_in;
    rd = rsp_data_in;
    valid_out = 1'b0;
    // Released lines wander so a stale value never passes
    code_out = ~c;
    data_out = ~d;
  endtask
  // Exponent zero; only legal intervals are sent
  task automatic set_interval(input int ms);
    logic g;
    logic [15:0] r;
    if (ms >= 120 && ms <= 1023) begin
      xfer(1'b1, `CODE_RESTART_INTERVAL, {5'h00, ms[10:0]}, g, r);
    end
  endtask
endmodule // pmbus_host_model
`default_nettype wire
